// File: hdl/pmwc_edge_sync.sv
/*
  Two-flop synchronisers and edge detectors for the wake inputs.
  Assumes raw inputs may change at any time relative to i_clk.
*/
`timescale 1ns/1ps
module pmwc_edge_sync (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [pmwc_pkg::PMWC_NSRC-1:0] i_src,
  input wire logic i_rst_pin,
  pmwc_evt_if.src evt
);
  localparam int W = pmwc_pkg::PMWC_NSRC + 1;
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // ==========================================================
  // synchronise; third stage only feeds edge detection
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= {i_rst_pin, i_src};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // sources wake on rising edge; reset pin on falling edge
  assign evt.src_evt = s2_reg[W-2:0] & ~s3_reg[W-2:0];
  assign evt.rst_fall = ~s2_reg[W-1] & s3_reg[W-1];
endmodule

// File: hdl/pmwc_top.sv
/*
  Power mode select and wake-up control: mode register, wake-config
  register, wake flags and low power state sequencing.
  Assumes a CPU register bus with one-cycle write and read strobes and
  a page selector; event inputs are asynchronous.
*/
`timescale 1ns/1ps
module pmwc_top (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [3:0] i_page,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_hit,
  input wire logic i_osc_fail,
  input wire logic i_rtc_alarm,
  input wire logic i_port_match,
  input wire logic i_cmp_out,
  input wire logic i_rst_pin,
  output logic o_sleep,
  output logic o_suspend,
  output logic o_clk_gate,
  output logic o_lpo_keep_on,
  output logic o_stop_pulse,
  output logic o_idle_pulse
);
  pmwc_evt_if evt_bus ();
  pmwc_pkg::pmwc_state_t state_reg;
  logic [pmwc_pkg::PMWC_NSRC-1:0] en_reg;
  logic [pmwc_pkg::PMWC_NSRC-1:0] flag_reg;
  logic rst_flag_reg;
  logic sleep_mode_reg;
  logic [pmwc_pkg::PMWC_GP_W-1:0] gp_reg;
  logic [1:0] blank_reg;
  logic stop_reg;
  logic idle_reg;
  logic wr_mode;
  logic wr_wake;
  logic any_flag;
  logic wake_hit;
  logic lp_req;
  logic [3:0] srcs_raw;

  // ==========================================================
  // address decode, shared by read and write paths
  function automatic logic is_wake(input logic [7:0] a, input logic [3:0] p);
    is_wake = (a == pmwc_pkg::PMWC_ADDR_WAKE) && (p == pmwc_pkg::PMWC_PAGE_WAKE);
  endfunction

  function automatic logic is_mode(input logic [7:0] a);
    is_mode = (a == pmwc_pkg::PMWC_ADDR_MODE);
  endfunction

  assign wr_mode = i_wr && is_mode(i_addr);
  assign wr_wake = i_wr && is_wake(i_addr, i_page);
  assign srcs_raw = {i_osc_fail, i_rtc_alarm, i_port_match, i_cmp_out};

  pmwc_edge_sync u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_src(srcs_raw),
    .i_rst_pin(i_rst_pin),
    .evt(evt_bus.src)
  );

  // ==========================================================
  // wake flags and combined status
  assign any_flag = rst_flag_reg || (|flag_reg);
  // enabled source or reset pin ends low power
  assign wake_hit = (|(evt_bus.src_evt & en_reg)) || evt_bus.rst_fall;
  assign lp_req = wr_wake &&
    (i_wdata[pmwc_pkg::PMWC_B_SLEEP] || i_wdata[pmwc_pkg::PMWC_B_SUSP]);

  // source flags: events always set flags 1 to 3, set beats clear-all
  // comparator flag only records a comparator-caused wake
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_reg <= '0;
    end else begin
      for (int i = 1; i < pmwc_pkg::PMWC_NSRC; i++) begin
        if (evt_bus.src_evt[i]) begin
          flag_reg[i] <= 1'b1;
        end else if (wr_wake && i_wdata[pmwc_pkg::PMWC_B_CLEAR]) begin
          flag_reg[i] <= 1'b0;
        end
      end
      if (evt_bus.src_evt[0] && en_reg[0] && state_reg == pmwc_pkg::PMWC_LOWP) begin
        flag_reg[0] <= 1'b1;
      end else if (wr_wake && i_wdata[pmwc_pkg::PMWC_B_CLEAR]) begin
        flag_reg[0] <= 1'b0;
      end
    end
  end

  // reset pin flag, hardware set only, software write cannot set it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_flag_reg <= 1'b0;
    end else if (evt_bus.rst_fall) begin
      rst_flag_reg <= 1'b1;
    end else if (wr_wake && i_wdata[pmwc_pkg::PMWC_B_CLEAR]) begin
      rst_flag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // enables: written on every wake-config write, rearmed by the
  // same write that enters low power
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_reg <= pmwc_pkg::PMWC_EN_RST;
    end else if (wr_wake) begin
      en_reg <= i_wdata[pmwc_pkg::PMWC_NSRC-1:0];
    end
  end

  // ==========================================================
  // low power sequencer
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= pmwc_pkg::PMWC_RUN;
      sleep_mode_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        pmwc_pkg::PMWC_RUN: begin
          // pending flags veto entry; clear-all in the same write does not help
          if (lp_req && !any_flag) begin
            state_reg <= pmwc_pkg::PMWC_LOWP;
            sleep_mode_reg <= i_wdata[pmwc_pkg::PMWC_B_SLEEP];
          end
        end
        pmwc_pkg::PMWC_LOWP: begin
          if (wake_hit) begin
            state_reg <= pmwc_pkg::PMWC_WAKE;
          end
        end
        pmwc_pkg::PMWC_WAKE: begin
          if (blank_reg == 2'h1) begin
            state_reg <= pmwc_pkg::PMWC_RUN;
            sleep_mode_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= pmwc_pkg::PMWC_RUN;
        end
      endcase
    end
  end

  // read blanking counter after wake
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      blank_reg <= '0;
    end else if (state_reg == pmwc_pkg::PMWC_LOWP && wake_hit) begin
      blank_reg <= pmwc_pkg::PMWC_BLANK_CYC;
    end else if (blank_reg != '0) begin
      blank_reg <= blank_reg - 2'h1;
    end
  end

  assign o_sleep = (state_reg == pmwc_pkg::PMWC_LOWP) && sleep_mode_reg;
  assign o_suspend = (state_reg == pmwc_pkg::PMWC_LOWP) && !sleep_mode_reg;
  assign o_clk_gate = (state_reg == pmwc_pkg::PMWC_LOWP);
  assign o_lpo_keep_on = any_flag;

  // ==========================================================
  // mode register: general bits plus stop and idle strobes
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gp_reg <= pmwc_pkg::PMWC_GP_RST;
    end else if (wr_mode) begin
      gp_reg <= i_wdata[pmwc_pkg::PMWC_GP_LO +: pmwc_pkg::PMWC_GP_W];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stop_reg <= 1'b0;
      idle_reg <= 1'b0;
    end else begin
      stop_reg <= wr_mode && i_wdata[pmwc_pkg::PMWC_B_STOP];
      idle_reg <= wr_mode && i_wdata[pmwc_pkg::PMWC_B_IDLE];
    end
  end

  assign o_stop_pulse = stop_reg;
  assign o_idle_pulse = idle_reg;

  // ==========================================================
  // read data, registered; strobe bits read zero
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= '0;
      o_hit <= 1'b0;
    end else begin
      o_hit <= i_rd && (is_mode(i_addr) || is_wake(i_addr, i_page));
      if (i_rd && is_mode(i_addr)) begin
        o_rdata <= {gp_reg, 2'b00};
      end else if (i_rd && is_wake(i_addr, i_page)) begin
        // flags hidden while the unit settles after a wake
        o_rdata <= (blank_reg != '0 || state_reg == pmwc_pkg::PMWC_WAKE) ? 8'h00 :
          {3'b000, rst_flag_reg, flag_reg};
      end else begin
        o_rdata <= '0;
      end
    end
  end

  // ==========================================================
  // checks
  flag_veto_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == pmwc_pkg::PMWC_RUN && any_flag) |=> state_reg != pmwc_pkg::PMWC_LOWP)
    else $error("entered low power with a flag set");
  rst_wake_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == pmwc_pkg::PMWC_LOWP && evt_bus.rst_fall) |=> !o_clk_gate ##1 rst_flag_reg)
    else $error("reset pin edge did not wake");
  clear_all_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (wr_wake && i_wdata[pmwc_pkg::PMWC_B_CLEAR] && !(|evt_bus.src_evt) && !evt_bus.rst_fall)
    |=> !any_flag)
    else $error("clear-all left a flag");
  flag_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    evt_bus.src_evt[1] |=> flag_reg[1])
    else $error("port match flag not set");
  blank_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == pmwc_pkg::PMWC_WAKE && i_rd && is_wake(i_addr, i_page)) |=> o_rdata == 8'h00)
    else $error("flags visible during wake blanking");
  wake_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == pmwc_pkg::PMWC_LOWP && wake_hit) |=>
    state_reg == pmwc_pkg::PMWC_WAKE ##1 state_reg == pmwc_pkg::PMWC_WAKE
    ##1 state_reg == pmwc_pkg::PMWC_RUN)
    else $error("wake blanking length wrong");
  stop_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (wr_mode && i_wdata[pmwc_pkg::PMWC_B_STOP]) |=> o_stop_pulse ##1 !o_stop_pulse || $past(wr_mode))
    else $error("stop strobe wrong");
  gp_keep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_mode |=> gp_reg == $past(i_wdata[7:2]))
    else $error("general bits not stored");
  enable_arm_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_wake |=> en_reg == $past(i_wdata[3:0]))
    else $error("enables not armed");
endmodule

// File: shared/pmwc_evt_if.sv
/*
  Interface carrying synchronised wake events from the edge stage to
  the main control logic.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface pmwc_evt_if;
  logic [pmwc_pkg::PMWC_NSRC-1:0] src_evt;
  logic rst_fall;
  modport src (output src_evt, output rst_fall);
  modport dst (input src_evt, input rst_fall);
endinterface

// File: shared/pmwc_pkg.sv
/*
  Constants for the power mode and wake-up control block: register
  addresses, bit positions, reset values and timing.
  Assumes an 8-bit special function register bus with a page selector.
*/
package pmwc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] PMWC_ADDR_MODE = 8'h87;
  localparam logic [7:0] PMWC_ADDR_WAKE = 8'hb5;
  localparam logic [3:0] PMWC_PAGE_WAKE = 4'h0;

  // ==========================================================
  // wake-config bit positions
  localparam int PMWC_B_SLEEP = 7;
  localparam int PMWC_B_SUSP = 6;
  localparam int PMWC_B_CLEAR = 5;
  localparam int PMWC_B_RESET_PIN_WAKE_FLAG = 4;
  localparam int PMWC_NSRC = 4;

  // ==========================================================
  // mode register bit positions
  localparam int PMWC_B_STOP = 1;
  localparam int PMWC_B_IDLE = 0;
  localparam int PMWC_GP_LO = 2;
  localparam int PMWC_GP_W = 6;

  // ==========================================================
  // reset values and timing
  localparam logic [5:0] PMWC_GP_RST = 6'h00;
  localparam logic [3:0] PMWC_EN_RST = 4'h0;
  localparam logic [1:0] PMWC_BLANK_CYC = 2'h2;

  typedef enum logic [1:0] {
    PMWC_RUN = 2'b00,
    PMWC_LOWP = 2'b01,
    PMWC_WAKE = 2'b11
  } pmwc_state_t;

endpackage

// File: sim/pmwc_tb.sv
/*
  Self-checking bench for the power mode and wake-up control block.
  Assumes a 20 MHz system clock and direct drive of the register strobes and event pins.
*/
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [3:0] i_page = 4'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic [3:0] ev = 4'h0;
  logic i_rst_pin = 1'b1;
  logic [7:0] o_rdata;
  logic o_hit, o_sleep, o_suspend, o_clk_gate, o_lpo_keep_on, o_stop_pulse, o_idle_pulse;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  logic [5:0] gp;
  logic [3:0] pg;
  logic [7:0] ua;
  // time of the last strobe release, so a back-to-back request lets an edge pass first
  time t_wr = 0;
  time t_rd = 0;

  pmwc_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_page(i_page),
    .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_hit(o_hit),
    .i_osc_fail(ev[3]), .i_rtc_alarm(ev[2]), .i_port_match(ev[1]), .i_cmp_out(ev[0]),
    .i_rst_pin(i_rst_pin), .o_sleep(o_sleep), .o_suspend(o_suspend), .o_clk_gate(o_clk_gate),
    .o_lpo_keep_on(o_lpo_keep_on), .o_stop_pulse(o_stop_pulse), .o_idle_pulse(o_idle_pulse));

  // ==========================================================
  // clock and hang guard
  always #25 i_clk = ~i_clk;

  // ceiling well above the roughly 150 cycles the sequence needs
  always @(posedge i_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      n_fail++;
      results();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // inputs always move 2 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask

  // whole-byte writes only, never read-modify-write: reads return flags
  task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    if ($time == t_wr) cyc(1);
    i_addr = a;
    i_page = p;
    i_wdata = d;
    i_wr = 1'b1;
    cyc(1);
    i_wr = 1'b0;
    t_wr = $time;
  endtask

  // read data and hit are registered, so they are looked at one edge later
  task automatic rd(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d,
                    input logic h);
    if ($time == t_rd) cyc(1);
    i_addr = a;
    i_page = p;
    i_rd = 1'b1;
    cyc(1);
    i_rd = 1'b0;
    t_rd = $time;
    chk(o_rdata, d);
    chk(o_hit, h);
  endtask

  // events must stay stable past the two synchroniser flops
  task automatic ev_pulse(input int b);
    ev[b] = 1'b1;
    cyc(4);
    ev[b] = 1'b0;
    cyc(4);
  endtask

  task automatic wgate();
    int k;
    k = 0;
    while (o_clk_gate !== 1'b0 && k < 40) begin
      cyc(1);
      k++;
    end
    chk(o_clk_gate, 1'b0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(48378));
    repeat (4) @(posedge i_clk);
    #2;
    i_nrst = 1'b1;
    rd(8'h87, 4'h0, 8'h00, 1'b1);
    rd(8'hb5, 4'h0, 8'h00, 1'b1);
    // random storage, any page, wrong page and unmapped places
    for (int i = 0; i < 8; i++) begin
      gp = 6'($urandom);
      pg = 4'($urandom);
      wr(8'h87, pg, {gp, 2'b00});
      rd(8'h87, 4'($urandom), {gp, 2'b00}, 1'b1);
      rd(8'hb5, 4'($urandom_range(15, 1)), 8'h00, 1'b0);
      ua = 8'($urandom);
      if (ua == 8'h87 || ua == 8'hb5) ua = 8'h00;
      rd(ua, pg, 8'h00, 1'b0);
    end
    // mode strobes are pulses and read back as zero
    wr(8'h87, 4'h3, 8'hfe);
    chk(o_stop_pulse, 1'b1);
    chk(o_idle_pulse, 1'b0);
    cyc(1);
    chk(o_stop_pulse, 1'b0);
    rd(8'h87, 4'h0, 8'hfc, 1'b1);
    wr(8'h87, 4'h0, 8'h01);
    chk(o_idle_pulse, 1'b1);
    cyc(1);
    chk(o_idle_pulse, 1'b0);
    rd(8'h87, 4'h0, 8'h00, 1'b1);
    // flags while running block sleep even with clear in the same write
    ev_pulse(3);
    ev_pulse(2);
    rd(8'hb5, 4'h0, 8'h0c, 1'b1);
    chk(o_lpo_keep_on, 1'b1);
    wr(8'hb5, 4'h0, 8'ha2);
    chk(o_sleep, 1'b0);
    chk(o_clk_gate, 1'b0);
    rd(8'hb5, 4'h0, 8'h00, 1'b1);
    chk(o_lpo_keep_on, 1'b0);
    wr(8'hb5, 4'h0, 8'h10);
    rd(8'hb5, 4'h0, 8'h00, 1'b1);
    // sleep, port match wake, blanked flags just after
    wr(8'hb5, 4'h0, 8'h82);
    chk({o_sleep, o_suspend, o_clk_gate}, 8'h05);
    ev[1] = 1'b1;
    wgate();
    rd(8'hb5, 4'h0, 8'h00, 1'b1);
    cyc(2);
    rd(8'hb5, 4'h0, 8'h02, 1'b1);
    ev[1] = 1'b0;
    cyc(4);
    wr(8'hb5, 4'h0, 8'h20);
    // disabled source only flags; reset pin always wakes
    wr(8'hb5, 4'h0, 8'h84);
    ev_pulse(1);
    chk(o_clk_gate, 1'b1);
    i_rst_pin = 1'b0;
    wgate();
    cyc(3);
    rd(8'hb5, 4'h0, 8'h12, 1'b1);
    i_rst_pin = 1'b1;
    cyc(4);
    wr(8'hb5, 4'h0, 8'h20);
    // suspend with comparator wake
    wr(8'hb5, 4'h0, 8'h41);
    chk({o_sleep, o_suspend, o_clk_gate}, 8'h03);
    ev[0] = 1'b1;
    wgate();
    cyc(3);
    rd(8'hb5, 4'h0, 8'h01, 1'b1);
    ev[0] = 1'b0;
    cyc(4);
    wr(8'hb5, 4'h0, 8'h20);
    // both select bits written: sleep wins
    wr(8'hb5, 4'h0, 8'hc4);
    chk({o_sleep, o_suspend, o_clk_gate}, 8'h05);
    ev_pulse(2);
    chk(o_clk_gate, 1'b0);
    rd(8'hb5, 4'h0, 8'h04, 1'b1);
    wr(8'hb5, 4'h0, 8'h20);
    // comparator edge while running did not cause a wake
    ev_pulse(0);
    rd(8'hb5, 4'h0, 8'h00, 1'b1);
    results();
  end
endmodule
